// ==== hw/dcf_consts.vh ====
// Notes on behaviour
// - Reset low returns read and write pointers to the first location; reset before writing.
// - Reset sets half-full and almost-full high, almost-empty low, full flag high in standard mode, input-ready low in fall-through.
// - Reset drives empty/output-ready low in standard mode, high in fall-through mode.
// - Reset clears the output register and loads both offset registers with defaults.
// - Write enable low and not full stores the 18-bit word at the next location.
// - Standard mode: full flag low when memory full, high after a read; write clock.
// - Fall-through: input-ready high with no free space, low after a read; write clock.
// - Write enable is ignored while full in both modes.
// - Read enable low and not empty loads the next word; otherwise outputs hold, except the fall-through first word.
// - Standard mode: each word needs an enabled read; empty flag low after last word.
// - Standard mode: empty flag goes high after a write into empty FIFO; read clock.
// - Fall-through: first word appears without read enable on third read edge after write.
// - Fall-through: output-ready goes high only on an enabled read after the last word.
// - Output enable low drives the output register; high floats the output bus.
// - Load and write enable low: first edge writes empty offset, second full offset.
// - A third loading edge targets the empty offset register again.
// - Loading may stop after one register; next load continues the sequence.
// - Load low with write enable high neither advances the pointer nor writes.
// - Load and read enable low read offsets out with own pointer; standard mode only.
// - Standard mode: full flag low after depth writes with no reads.
// - Fall-through: input-ready high after depth plus one writes.
// - Almost-empty low at or below empty offset, or offset plus one in fall-through.
`ifndef DCF_CONSTS_VH
`define DCF_CONSTS_VH
`define DCF_DW 18
`define DCF_AW 8
`define DCF_DEPTH 9'h100
`define DCF_CW 9
`define DCF_HALF 9'h080
`define DCF_OW 12
`define DCF_EMPTY_OFS_RST 12'h01F
`define DCF_FULL_OFS_RST 12'h01F
`define DCF_SEL_EMPTY 1'b0
`define DCF_SEL_FULL 1'b1
`endif

// ==== hw/dcf_ram.v ====
`include "dcf_consts.vh"
module dcf_ram (
    // Write side
    input wire i_mclk,
    input wire i_we,
    input wire [`DCF_AW-1:0] i_waddr,
    input wire [`DCF_DW-1:0] i_wdata,
    // Read side, registered
    input wire [`DCF_AW-1:0] i_raddr,
    output reg [`DCF_DW-1:0] o_rdata
);
    reg [`DCF_DW-1:0] mem [0:(1<<`DCF_AW)-1];

    // No reset on the array; contents are only valid once written
    always @(posedge i_mclk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule // dcf_ram

// ==== hw/dcf_fifo.v ====
`include "dcf_consts.vh"
module dcf_fifo (
    // Clock and reset
    input wire i_mclk,
    input wire i_rst_b,
    // Configuration straps
    input wire i_fall_through_mode,
    input wire i_first_load_strap,
    input wire i_write_expansion_in,
    input wire i_read_expansion_in,
    // Write port
    input wire i_wen_n,
    input wire i_offset_load_n,
    input wire [`DCF_DW-1:0] i_write_data_bus,
    // Read port
    input wire i_ren_n,
    input wire i_oe_n,
    output reg [`DCF_DW-1:0] o_read_data_bus,
    output reg o_read_data_oe,
    // Flags
    output reg o_full_flag_n,
    output reg o_empty_flag_n,
    output reg o_half_full_n,
    output reg o_almost_full_n,
    output reg o_almost_empty_n,
    output reg o_read_expansion_out
);
    // Mode is caught after reset release; straps are static in use
    reg fall_through_mode;
    reg mode_taken;
    reg [`DCF_AW:0] wptr;
    reg [`DCF_AW:0] rptr;
    reg [`DCF_DW-1:0] outreg;
    reg out_valid;
    reg [`DCF_OW-1:0] empty_offset;
    reg [`DCF_OW-1:0] full_offset;
    reg wsel;
    reg rsel;
    reg [1:0] fall_cnt;
    wire [`DCF_DW-1:0] ram_q;
    wire [`DCF_CW-1:0] mem_cnt;
    wire [`DCF_CW:0] tot_cnt;
    wire loading;
    wire mem_full;
    wire mem_empty;
    wire do_write;
    wire std_read;
    wire fall_through_mode_shift;
    wire do_pop;
    wire off_read;
    wire [`DCF_AW:0] rptr_nx;
    wire [`DCF_CW-1:0] cnt_nx;
    wire [`DCF_CW:0] tot_nx;
    reg wr_hit;
    reg [`DCF_DW-1:0] wr_hold;
    wire [`DCF_DW-1:0] pop_word;
    wire [`DCF_DW-1:0] ofs_word;
    reg next_full_n;
    reg next_empty_n;
    reg next_half_n;
    reg next_afull_n;
    reg next_aempty_n;
    reg next_rxo;

    // Offset readback word; bits above the offset width read as zero
    function [`DCF_DW-1:0] dcf_ofs_word;
        input sel;
        input [`DCF_OW-1:0] e;
        input [`DCF_OW-1:0] f;
        begin
            dcf_ofs_word = {{(`DCF_DW-`DCF_OW){1'b0}}, (sel ? f : e)};
        end
    endfunction

    // Pointer arithmetic used for both pointers
    function [`DCF_AW:0] dcf_inc;
        input [`DCF_AW:0] p;
        begin
            dcf_inc = p + {{`DCF_AW{1'b0}}, 1'b1};
        end
    endfunction

    // Offset in the counter's width
    function [`DCF_CW:0] dcf_ofs;
        input [`DCF_OW-1:0] o;
        begin
            dcf_ofs = {1'b0, o[`DCF_CW-1:0]};
        end
    endfunction

    assign mem_cnt = wptr - rptr;
    assign mem_full = (mem_cnt == `DCF_DEPTH);
    assign mem_empty = (mem_cnt == {`DCF_CW{1'b0}});
    assign loading = ~i_offset_load_n;
    // Writes ignored while full; loading edges never store data
    assign do_write = ~i_wen_n & ~loading & ~mem_full;
    // Standard read: explicit enable, blocked when empty
    assign std_read = ~fall_through_mode & ~i_ren_n & ~loading & ~mem_empty;
    // Fall-through refills the output stage when it is empty or being taken
    assign fall_through_mode_shift = fall_through_mode & ~mem_empty
        & (~out_valid ? (fall_cnt == 2'd2) : (~i_ren_n));
    assign do_pop = std_read | fall_through_mode_shift;
    assign off_read = ~fall_through_mode & loading & ~i_ren_n;
    assign rptr_nx = do_pop ? dcf_inc(rptr) : rptr;
    assign cnt_nx = wptr + (do_write ? 9'h001 : 9'h000) - rptr_nx;
    // Word total counts the output stage in fall-through mode
    assign tot_nx = {1'b0, cnt_nx} + {{`DCF_CW{1'b0}},
        (fall_through_mode & ((out_valid & ~(~i_ren_n & ~fall_through_mode_shift)) | fall_through_mode_shift))};
    assign tot_cnt = {1'b0, mem_cnt};

    dcf_ram u_ram (
        .i_mclk(i_mclk),
        .i_we(do_write),
        .i_waddr(wptr[`DCF_AW-1:0]),
        .i_wdata(i_write_data_bus),
        .i_raddr(rptr_nx[`DCF_AW-1:0]),
        .o_rdata(ram_q)
    );

    // The RAM reads before it writes, so a word written to the address that
    // is being fetched comes out stale for one cycle. A read right after the
    // first write into an empty FIFO hits this case, so the written word is
    // kept for one cycle and stands in for the RAM output.
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_hit <= 1'b0;
            wr_hold <= {`DCF_DW{1'b0}};
        end else begin
            wr_hit <= do_write & (wptr[`DCF_AW-1:0] == rptr_nx[`DCF_AW-1:0]);
            if (do_write) begin
                wr_hold <= i_write_data_bus;
            end
        end
    end

    // Word handed to the output stage, and the offset word for readback
    assign pop_word = wr_hit ? wr_hold : ram_q;
    assign ofs_word = dcf_ofs_word(rsel, empty_offset, full_offset);

    // Mode latch at first edge after reset release
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode_taken <= 1'b0;
            fall_through_mode <= 1'b0;
        end else if (!mode_taken) begin
            mode_taken <= 1'b1;
            fall_through_mode <= i_fall_through_mode;
        end
    end

    // Data pointers
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wptr <= {(`DCF_AW+1){1'b0}};
            rptr <= {(`DCF_AW+1){1'b0}};
        end else begin
            if (do_write) begin
                wptr <= dcf_inc(wptr);
            end
            rptr <= rptr_nx;
        end
    end

    // Fall-through latency: first word lands on third read edge after its write
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fall_cnt <= 2'd0;
        end else if (!fall_through_mode || out_valid || mem_empty || fall_through_mode_shift) begin
            fall_cnt <= 2'd0;
        end else if (fall_cnt != 2'd2) begin
            fall_cnt <= fall_cnt + 2'd1;
        end
    end

    // Output register; RAM data registered at pop address is shown a cycle on
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            outreg <= {`DCF_DW{1'b0}};
            out_valid <= 1'b0;
        end else begin
            if (off_read) begin
                outreg <= ofs_word;
            end else if (do_pop) begin
                outreg <= pop_word;
            end
            if (fall_through_mode_shift) begin
                out_valid <= 1'b1;
            end else if (fall_through_mode & ~i_ren_n) begin
                out_valid <= 1'b0;
            end
        end
    end

    // Offset registers and their selection pointers
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            empty_offset <= `DCF_EMPTY_OFS_RST;
            full_offset <= `DCF_FULL_OFS_RST;
            wsel <= `DCF_SEL_EMPTY;
            rsel <= `DCF_SEL_EMPTY;
        end else begin
            if (loading && !i_wen_n) begin
                if (wsel == `DCF_SEL_EMPTY) begin
                    empty_offset <= i_write_data_bus[`DCF_OW-1:0];
                end else begin
                    full_offset <= i_write_data_bus[`DCF_OW-1:0];
                end
                wsel <= ~wsel;
            end
            if (off_read) begin
                rsel <= ~rsel;
            end
        end
    end

    // Next flag values, worked out from the counts as they stand after this edge
    always @* begin
        next_full_n = 1'b1;
        next_empty_n = 1'b0;
        if (fall_through_mode) begin
            // Input ready is high only when memory and output stage are both taken
            next_full_n = (cnt_nx == `DCF_DEPTH)
                & (tot_nx == {1'b0, `DCF_DEPTH} + 10'h001);
            // Output ready stays low until a true read takes the last word
            next_empty_n = ~(fall_through_mode_shift | (out_valid & i_ren_n));
        end else begin
            next_full_n = ~(cnt_nx == `DCF_DEPTH);
            next_empty_n = (cnt_nx != {`DCF_CW{1'b0}});
        end
        // Partial flags count the output stage as a word in fall-through mode
        next_half_n = ~(tot_nx > {1'b0, `DCF_HALF});
        next_afull_n = ~(tot_nx + dcf_ofs(full_offset) >=
            {1'b0, `DCF_DEPTH} + {9'h000, fall_through_mode});
        next_aempty_n = (tot_nx > dcf_ofs(empty_offset)
            + {9'h000, fall_through_mode});
        // Pulse when the last memory location is read
        next_rxo = do_pop & (rptr[`DCF_AW-1:0] == {`DCF_AW{1'b1}});
    end

    // Flags, registered on the clock edge
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_full_flag_n <= 1'b1;
            o_empty_flag_n <= 1'b0;
            o_half_full_n <= 1'b1;
            o_almost_full_n <= 1'b1;
            o_almost_empty_n <= 1'b0;
            o_read_expansion_out <= 1'b0;
        end else if (!mode_taken) begin
            o_full_flag_n <= ~i_fall_through_mode;
            o_empty_flag_n <= i_fall_through_mode;
            o_half_full_n <= 1'b1;
            o_almost_full_n <= 1'b1;
            o_almost_empty_n <= 1'b0;
            o_read_expansion_out <= 1'b0;
        end else begin
            o_full_flag_n <= next_full_n;
            o_empty_flag_n <= next_empty_n;
            o_half_full_n <= next_half_n;
            o_almost_full_n <= next_afull_n;
            o_almost_empty_n <= next_aempty_n;
            o_read_expansion_out <= next_rxo;
        end
    end

    // Three-state control; the bench resolves the bus from the enable
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_read_data_bus <= {`DCF_DW{1'b0}};
            o_read_data_oe <= 1'b0;
        end else begin
            // Bus mirrors what the output register takes at this edge
            o_read_data_bus <= off_read ? ofs_word : (do_pop ? pop_word : outreg);
            o_read_data_oe <= ~i_oe_n;
        end
    end

    // Expansion inputs and first-load strap are left unused here; only single-device use is built
    wire unused_straps = i_first_load_strap ^ i_write_expansion_in ^ i_read_expansion_in ^
        tot_cnt[0];
endmodule // dcf_fifo

// ==== verif/dcf_fifo_chk.sv ====
`include "dcf_consts.vh"
module dcf_chk (
    // Clock, reset and mode strap
    input wire i_mclk,
    input wire i_rst_b,
    input wire i_fall_through_mode,
    // Port controls
    input wire i_wen_n,
    input wire i_offset_load_n,
    input wire i_ren_n,
    input wire i_oe_n,
    // Outputs under watch
    input wire [`DCF_DW-1:0] o_read_data_bus,
    input wire o_read_data_oe,
    input wire o_full_flag_n,
    input wire o_empty_flag_n,
    input wire o_half_full_n,
    input wire o_almost_full_n,
    input wire o_almost_empty_n
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    // Values seen at the first edge after release are the reset values
    rst_flags_a: assert property ($rose(i_rst_b) |-> o_full_flag_n && o_half_full_n
        && o_almost_full_n && !o_almost_empty_n && o_read_data_bus == '0)
        else $error("reset flag or data value wrong");
    mode_empty_a: assert property ($rose(i_rst_b) |->
        !o_empty_flag_n ##1 o_empty_flag_n == i_fall_through_mode)
        else $error("empty flag after reset does not follow mode");
    // Flags only move on the documented cause; a read last cycle may still land now
    full_holds_a: assert property (!i_fall_through_mode && !o_full_flag_n
        && i_ren_n && $past(i_ren_n) |=> !o_full_flag_n)
        else $error("full flag cleared without a read");
    empty_holds_a: assert property (!i_fall_through_mode && !o_empty_flag_n
        && i_wen_n && $past(i_wen_n) |=> !o_empty_flag_n)
        else $error("empty flag cleared without a write");
    empty_rises_a: assert property (!i_fall_through_mode && !o_empty_flag_n
        && !i_wen_n && i_offset_load_n |-> ##[1:3] o_empty_flag_n)
        else $error("empty flag stuck after a write");
    full_clears_a: assert property (!i_fall_through_mode && !o_full_flag_n
        && !i_ren_n && i_offset_load_n |-> ##[1:3] o_full_flag_n)
        else $error("full flag stuck after a read");
    oe_float_a: assert property (i_oe_n ##1 i_oe_n |-> !o_read_data_oe)
        else $error("data bus driven while disabled");
    // Standard mode data only moves on an enabled read one or two edges back
    bus_hold_a: assert property (!i_fall_through_mode && $past(i_ren_n)
        && $past(i_ren_n, 2) |-> $stable(o_read_data_bus))
        else $error("output data changed without a read");
    fall_through_a: assert property (i_fall_through_mode && o_empty_flag_n
        && !i_wen_n && i_offset_load_n |-> ##[1:5] !o_empty_flag_n)
        else $error("first word did not fall through");
    ready_holds_a: assert property (i_fall_through_mode && !o_empty_flag_n
        && i_ren_n && $past(i_ren_n) && $past(i_rst_b) |=> !o_empty_flag_n)
        else $error("output ready dropped without a read");
endmodule // dcf_chk

bind dcf_fifo dcf_chk dcf_chk_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_fall_through_mode(i_fall_through_mode), .i_wen_n(i_wen_n), .i_ren_n(i_ren_n),
    .i_offset_load_n(i_offset_load_n), .i_oe_n(i_oe_n), .o_read_data_bus(o_read_data_bus),
    .o_read_data_oe(o_read_data_oe), .o_full_flag_n(o_full_flag_n),
    .o_empty_flag_n(o_empty_flag_n), .o_half_full_n(o_half_full_n),
    .o_almost_full_n(o_almost_full_n), .o_almost_empty_n(o_almost_empty_n));

// ==== verif/dcf_rdr.sv ====
module dcf_rdr (
    // Read port of the block
    input wire i_mclk,
    input wire [17:0] i_q,
    input wire i_q_oe,
    // Level seen on the shared bus
    output wire [17:0] o_wire
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [17:0] last = 18'h00000;
    // Remember what was driven last
    always @(posedge i_mclk) if (i_q_oe) last <= i_q;
    // No pull on the bus: a floated bus shows the inverse so stale data cannot pass
    assign o_wire = i_q_oe ? i_q : ~last;
endmodule // dcf_rdr

// ==== verif/tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic fall_through_mode = 1'b0;
    logic wen_n = 1'b1;
    logic ld_n = 1'b1;
    logic ren_n = 1'b1;
    logic oe_n = 1'b0;
    logic [17:0] d = 18'h00000;
    wire [17:0] q;
    wire [17:0] qw;
    wire q_oe, ff_n, ef_n, hf_n, af_n, ae_n, read_expansion_out;
    int fails = 0;
    int n_checks = 0;
    // Free-running 100 MHz clock
    always #5 clk = ~clk;
    // Straps tied for a single first-load device
    dcf_fifo dcf_fifo_inst (.i_mclk(clk), .i_rst_b(rst_b), .i_fall_through_mode(fall_through_mode),
        .i_first_load_strap(1'b0), .i_write_expansion_in(1'b0),
        .i_read_expansion_in(1'b0), .i_wen_n(wen_n), .i_offset_load_n(ld_n),
        .i_write_data_bus(d), .i_ren_n(ren_n), .i_oe_n(oe_n), .o_read_data_bus(q),
        .o_read_data_oe(q_oe), .o_full_flag_n(ff_n), .o_empty_flag_n(ef_n),
        .o_half_full_n(hf_n), .o_almost_full_n(af_n), .o_almost_empty_n(ae_n),
        .o_read_expansion_out(read_expansion_out));
    dcf_rdr dcf_rdr_inst (.i_mclk(clk), .i_q(q), .i_q_oe(q_oe), .o_wire(qw));
    // Drivers move 1 ns after the edge so the design never sees a race
    task automatic cyc; @(posedge clk); #1; endtask
    task automatic wr(logic [17:0] v); wen_n = 1'b0; d = v; cyc; endtask
    task automatic rd; ren_n = 1'b0; cyc; endtask
    task automatic idle; wen_n = 1'b1; ren_n = 1'b1; ld_n = 1'b1; cyc; endtask
    task automatic do_reset(logic m);
        rst_b = 1'b0;
        fall_through_mode = m;
        repeat (4) cyc;
        rst_b = 1'b1;
        cyc;
        cyc;
    endtask
    task automatic fill(int n);
        for (int i = 0; i < n; i++) wr(i[17:0]);
        idle;
    endtask
    task automatic chk_w(string s, logic [17:0] e, logic [17:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic chk_b(string s, logic e, logic g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s exp %b got %b", s, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        do_reset(1'b0);
        chk_b("ff", 1'b1, ff_n);
        chk_b("hf", 1'b1, hf_n);
        chk_b("ae", 1'b0, ae_n);
        chk_b("ef", 1'b0, ef_n);
        chk_w("q", 18'h00000, q);
        rd;
        idle;
        chk_w("q", 18'h00000, q);
        wr(18'h3FFFF);
        wr(18'h12345);
        wr(18'h00001);
        idle;
        chk_b("ef", 1'b1, ef_n);
        rd; idle; cyc; chk_w("q0", 18'h3FFFF, q);
        rd; idle; cyc; chk_w("q1", 18'h12345, q);
        rd; idle; cyc; chk_w("q2", 18'h00001, q);
        chk_b("ef", 1'b0, ef_n);
        rd; idle; cyc; chk_w("q", 18'h00001, q);
        oe_n = 1'b1;
        cyc;
        cyc;
        chk_b("oe", 1'b0, q_oe);
        chk_w("wire", 18'h3FFFE, qw);
        oe_n = 1'b0;
        cyc;
        cyc;
        chk_w("wire", 18'h00001, qw);
        // Offsets: empty, full, pause, empty again, then one more after leaving load
        ld_n = 1'b0;
        wr(18'h00ABC);
        wr(18'h00123);
        wen_n = 1'b1;
        cyc; cyc;
        wr(18'h00456);
        idle;
        ld_n = 1'b0;
        wr(18'h00789);
        idle;
        ld_n = 1'b0;
        rd; ren_n = 1'b1; cyc; cyc;
        chk_w("ofs_e", 18'h00456, {6'h00, q[11:0]});
        rd; idle; cyc;
        chk_w("ofs_f", 18'h00789, {6'h00, q[11:0]});
        // Standard fill to the brim, refused write, then drain
        do_reset(1'b0);
        fill(256);
        cyc;
        chk_b("ff", 1'b0, ff_n);
        chk_b("hf", 1'b0, hf_n);
        chk_b("af", 1'b0, af_n);
        chk_b("ae", 1'b1, ae_n);
        wr(18'h2AAAA); idle;
        rd; idle; cyc; chk_b("ff", 1'b1, ff_n);
        chk_w("first", 18'h00000, q);
        repeat (254) rd;
        rd; chk_b("rxo", 1'b1, read_expansion_out);
        idle; cyc;
        chk_w("last", 18'h000FF, q);
        chk_b("rxo", 1'b0, read_expansion_out);
        chk_b("ef", 1'b0, ef_n);
        // Fall-through mode
        do_reset(1'b1);
        chk_b("or", 1'b1, ef_n);
        wr(18'h0BEEF); idle; repeat (4) cyc;
        chk_b("or", 1'b0, ef_n);
        chk_w("ft", 18'h0BEEF, q);
        rd; idle; cyc; chk_b("or", 1'b1, ef_n);
        chk_w("ft", 18'h0BEEF, q);
        fill(256); repeat (3) cyc; chk_b("ir", 1'b0, ff_n);
        wr(18'h00100); idle; cyc; chk_b("ir", 1'b1, ff_n);
        give_verdict;
    end
    // Watchdog well beyond the roughly 8.5 microseconds the sequence needs
    initial begin
        #50000;
        fails++;
        give_verdict;
    end
endmodule // tb_top
